// ---- logic/ptg_pkg.sv ----
package ptg_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] PTG_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTG_MODE_OFS = 8'h04;
  localparam logic [7:0] PTG_PERIOD_OFS = 8'h08;
  localparam logic [7:0] PTG_COUNT_OFS = 8'h0C;
  localparam logic [7:0] PTG_STAT_OFS = 8'h10;
  localparam logic [7:0] PTG_CLR_OFS = 8'h14;
  localparam logic [7:0] PTG_IEN_OFS = 8'h18;

  // control register field positions, plus the status/enable/clear interrupt bit
  localparam int PTG_RUN_BIT = 0;
  localparam int PTG_SRC_BIT = 1;
  localparam int PTG_PRE_LSB = 4;
  localparam int PTG_POST_LSB = 8;
  localparam int PTG_IRQ_BIT = 0;

  // reset values
  localparam logic [7:0] PTG_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PTG_COUNT_RST = 8'h00;
  localparam logic [31:0] PTG_ZERO32 = 32'h0000_0000;

  // counter mode codes
  typedef enum logic [4:0] {
    PTG_M_SW_GATE = 5'b00000,
    PTG_M_GATE_HI_HOLD = 5'b00001,
    PTG_M_GATE_LO_HOLD = 5'b00010,
    PTG_M_LIM_ANY = 5'b00011,
    PTG_M_LIM_RISE = 5'b00100,
    PTG_M_LIM_FALL = 5'b00101,
    PTG_M_OS_SW = 5'b01000,
    PTG_M_OS_RISE = 5'b01001,
    PTG_M_OS_FALL = 5'b01010,
    PTG_M_OS_ANY = 5'b01011,
    PTG_M_MONO_RISE = 5'b10001,
    PTG_M_MONO_FALL = 5'b10010,
    PTG_M_MONO_ANY = 5'b10011
  } ptg_mode_t;

  // control fields that travel together
  typedef struct packed {
    logic [3:0] postscale_select;
    logic [2:0] prescale_select;
    logic clk_src_ext;
    logic run;
  } ptg_ctrl_t;

  localparam ptg_ctrl_t PTG_CTRL_RST = '0;

endpackage

// ---- logic/ptg_timer.sv ----
`timescale 1ns/100ps
// Overview of operation
// RQ1: edge-start modes need a fresh qualifying edge after run is set again.
// RQ2: stop-and-clear modes: after match, next clock clears run, holds zero.
// RQ3: stop-only modes: after match, next clock holds zero, run stays set.
// RQ4: postscaler counts matches, raises flag at selected ratio 1 to 16.
// RQ5: software enables the interrupt before postscaled events reach the cpu.
// RQ6: all-zero prescale and postscale fields both give ratio one.
// RQ7: non-instruction clocks: run and external signal take two timer clocks.
// RQ8: instruction clock: external signal one period late, run next period.
// RQ9: postscaled event reaches the flag within two instruction cycles.
// RQ10: software gate: count each prescaled clock while run, else hold.
// RQ11: free-running modes: at period match count wraps to zero, continues.
// RQ12: mode 00001 holds the counter while external signal is high.
// RQ13: mode 00010 holds the counter while external signal is low.
// RQ14: gated off, counter keeps its value for the pwm time base.
// RQ15: limit modes reset early on any, rising or falling external edge.
// RQ16: early reset ends period, restart two timer clocks after sync edge.
// RQ17: irq high while flag and enable set; flag held until cleared.
module ptg_timer
  import ptg_pkg::*;
#(
  parameter int INSTR_DIV = 4,
  parameter int COUNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_clock_in,
  input wire logic ext_gate_reset_input,
  output logic [COUNT_W-1:0] count_value,
  output logic postscaled_match,
  output logic irq
);

  // elaboration checks on parameters the logic cannot serve
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV must lie in 1..256");
  end
  if (COUNT_W != 8) begin : g_bad_w
    $error("COUNT_W must be 8");
  end

  ptg_ctrl_t ctrl_q;
  ptg_mode_t mode_q;
  logic [COUNT_W-1:0] period_q;
  logic [COUNT_W-1:0] count_q;
  logic irq_flag_q;
  logic irq_en_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic [7:0] div_q;
  logic instr_tick;
  logic tclk_s1_q, tclk_s2_q, tclk_prev_q;
  logic ext_tick;
  logic tick;
  logic ers_s1_q, ers_s2_q;
  logic ers_t1_q, ers_t2_q, ers_prev_q;
  logic ers_sel;
  logic run_t1_q, run_t2_q;
  logic run_eff;
  logic rise_edge, fall_edge, any_edge, qual_edge;
  logic armed_q;
  logic [6:0] presc_q;
  logic [6:0] presc_top;
  logic presc_roll;
  logic [3:0] post_q;
  logic match_ev;
  logic hw_stop;
  logic cycle_done;
  logic post_ev_q;
  logic wr_en, rd_setup;
  logic [31:0] rd_mux;
  logic addr_ok;

  // mode classes
  logic is_gate_hi, is_gate_lo, is_limit, is_stop_clr, is_stop_keep;
  logic is_edge_start;
  logic [1:0] edge_sel;
  logic gate_ok;

  assign is_gate_hi = (mode_q == PTG_M_GATE_HI_HOLD);
  assign is_gate_lo = (mode_q == PTG_M_GATE_LO_HOLD);
  assign is_limit = (mode_q == PTG_M_LIM_ANY) || (mode_q == PTG_M_LIM_RISE)
                    || (mode_q == PTG_M_LIM_FALL);
  assign is_stop_clr = (mode_q == PTG_M_OS_SW) || (mode_q == PTG_M_OS_RISE)
                       || (mode_q == PTG_M_OS_FALL)
                       || (mode_q == PTG_M_OS_ANY);
  assign is_stop_keep = (mode_q == PTG_M_MONO_RISE)
                        || (mode_q == PTG_M_MONO_FALL)
                        || (mode_q == PTG_M_MONO_ANY);
  // the software one-shot starts on run alone, so it is not edge-started
  assign is_edge_start = is_stop_keep || (is_stop_clr
                         && (mode_q != PTG_M_OS_SW));

  // edge-start codes carry the edge kind in their low bits; limit codes are mapped one by one
  always_comb begin
    case (mode_q)
      PTG_M_LIM_ANY, PTG_M_OS_ANY, PTG_M_MONO_ANY: edge_sel = 2'b11;
      PTG_M_LIM_RISE, PTG_M_OS_RISE, PTG_M_MONO_RISE: edge_sel = 2'b01;
      PTG_M_LIM_FALL, PTG_M_OS_FALL, PTG_M_MONO_FALL: edge_sel = 2'b10;
      default: edge_sel = 2'b00;
    endcase
  end

  // instruction clock enable, one pulse every INSTR_DIV pclk cycles
  // with INSTR_DIV of one the enable stays high, timer runs at pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(INSTR_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign instr_tick = (div_q == 8'(INSTR_DIV - 1));

  // external timer clock pin: two flops, then rising-edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_s1_q <= timer_clock_in;
      tclk_s2_q <= tclk_s1_q;
      tclk_prev_q <= tclk_s2_q;
    end
  end
  assign ext_tick = tclk_s2_q && !tclk_prev_q;
  // pin clock must stay below pclk/2, or a pulse slips between flops
  assign tick = ctrl_q.clk_src_ext ? ext_tick : instr_tick;

  // external reset/gate pin: metastability guard on pclk
  // these stages only guard against metastability; the tick stages
  // below give the delay that run and the gate signal share
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ers_s1_q <= 1'b0;
      ers_s2_q <= 1'b0;
    end else begin
      ers_s1_q <= ext_gate_reset_input;
      ers_s2_q <= ers_s1_q;
    end
  end

  // timer-clock sync of the external signal; the instruction clock
  // takes one stage, any other clock two full stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ers_t1_q <= 1'b0;
      ers_t2_q <= 1'b0;
      ers_prev_q <= 1'b0;
    end else if (tick) begin
      ers_t1_q <= ers_s2_q;
      ers_t2_q <= ers_t1_q;
      ers_prev_q <= ers_sel;
    end
  end
  assign ers_sel = ctrl_q.clk_src_ext ? ers_t2_q : ers_t1_q; // RQ7 RQ8

  // edges are judged per tick; a pulse shorter than a tick is lost
  assign rise_edge = ers_sel && !ers_prev_q;
  assign fall_edge = !ers_sel && ers_prev_q;
  assign any_edge = rise_edge || fall_edge;
  always_comb begin
    case (edge_sel)
      2'b01: qual_edge = rise_edge;
      2'b10: qual_edge = fall_edge;
      2'b11: qual_edge = any_edge;
      default: qual_edge = 1'b0;
    endcase
  end

  // run bit sync; a hardware stop flushes it so counting cannot resume
  // a stale run left in a stage would restart a finished one-shot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_t1_q <= 1'b0;
      run_t2_q <= 1'b0;
    end else if (hw_stop) begin
      run_t1_q <= 1'b0; // RQ2
      run_t2_q <= 1'b0;
    end else if (tick) begin
      run_t1_q <= ctrl_q.run;
      run_t2_q <= run_t1_q;
    end
  end
  assign run_eff = ctrl_q.clk_src_ext ? run_t2_q : run_t1_q; // RQ7 RQ8

  // edge-start arming: dropped when run falls or a cycle completes
  // an edge seen before run is effective cannot arm, a later one must
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (!run_eff || !is_edge_start || cycle_done) begin
      armed_q <= 1'b0; // RQ1
    end else if (tick && qual_edge) begin
      armed_q <= 1'b1; // RQ1
    end
  end

  // gate condition per mode; holding keeps the count for the pwm
  always_comb begin
    if (!run_eff) begin
      gate_ok = 1'b0; // RQ10 RQ14
    end else if (is_gate_hi) begin
      gate_ok = !ers_sel; // RQ12
    end else if (is_gate_lo) begin
      gate_ok = ers_sel; // RQ13
    end else if (is_edge_start) begin
      gate_ok = armed_q;
    end else if (mode_q == PTG_M_SW_GATE || is_limit
                 || mode_q == PTG_M_OS_SW) begin
      gate_ok = 1'b1; // RQ10
    end else begin
      gate_ok = 1'b0; // reserved codes hold
    end
  end

  // prescaler top is 2^select - 1, so select zero divides by one
  assign presc_top = 7'((8'h01 << ctrl_q.prescale_select) - 8'h01); // RQ6
  // greater-or-equal: a ratio lowered mid-count must not make the
  // prescaler run through all its states before the next rollover
  assign presc_roll = tick && gate_ok && (presc_q >= presc_top); // RQ6
  assign match_ev = presc_roll && (count_q == period_q);
  assign hw_stop = match_ev && is_stop_clr;
  // every edge-start mode ends its cycle at the match; the codes that
  // keep run set are stopped by dropping the arming flop alone
  assign cycle_done = match_ev && is_edge_start; // RQ3

  // prescaler; an early limit reset restarts it with the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 7'h00;
    end else if (tick && run_eff && is_limit && qual_edge) begin
      presc_q <= 7'h00; // RQ16
    end else if (tick && gate_ok) begin
      presc_q <= presc_roll ? 7'h00 : presc_q + 7'h01;
    end
  end

  // main counter, with software write access
  // a write beats counting, so writing zero restarts the period cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= PTG_COUNT_RST;
    end else if (wr_en && paddr == PTG_COUNT_OFS) begin
      count_q <= pwdata[COUNT_W-1:0];
    end else if (tick && run_eff && is_limit && qual_edge) begin
      count_q <= PTG_COUNT_RST; // RQ15 RQ16
    end else if (match_ev) begin
      count_q <= PTG_COUNT_RST; // RQ11 RQ2 RQ3
    end else if (presc_roll) begin
      count_q <= count_q + 8'h01; // RQ10
    end
  end
  assign count_value = count_q;

  // postscaler: select value n gives ratio n+1
  // greater-or-equal also catches a ratio lowered below the running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= 4'h0;
      post_ev_q <= 1'b0;
    end else begin
      post_ev_q <= 1'b0;
      if (match_ev) begin
        if (post_q >= ctrl_q.postscale_select) begin
          post_q <= 4'h0; // RQ4 RQ6
          post_ev_q <= 1'b1; // RQ4
        end else begin
          post_q <= post_q + 4'h1;
        end
      end
    end
  end
  assign postscaled_match = post_ev_q;

  // flag: one pclk after the postscaled pulse; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_q <= 1'b0;
    end else if (post_ev_q) begin
      irq_flag_q <= 1'b1; // RQ9 RQ17
    end else if (wr_en && paddr == PTG_CLR_OFS && pwdata[PTG_IRQ_BIT]) begin
      irq_flag_q <= 1'b0; // RQ17
    end
  end
  assign irq = irq_flag_q && irq_en_q; // RQ17 RQ5

  // apb decode; writes land in the access phase, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = PTG_ZERO32;
    case (paddr)
      PTG_CTRL_OFS: begin
        rd_mux[PTG_RUN_BIT] = ctrl_q.run;
        rd_mux[PTG_SRC_BIT] = ctrl_q.clk_src_ext;
        rd_mux[PTG_PRE_LSB +: 3] = ctrl_q.prescale_select;
        rd_mux[PTG_POST_LSB +: 4] = ctrl_q.postscale_select;
      end
      PTG_MODE_OFS: rd_mux[4:0] = mode_q;
      PTG_PERIOD_OFS: rd_mux[COUNT_W-1:0] = period_q;
      PTG_COUNT_OFS: rd_mux[COUNT_W-1:0] = count_q;
      PTG_STAT_OFS: rd_mux[PTG_IRQ_BIT] = irq_flag_q;
      PTG_CLR_OFS: rd_mux = PTG_ZERO32; // write-only, reads zero
      PTG_IEN_OFS: rd_mux[PTG_IRQ_BIT] = irq_en_q;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data and error are captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= PTG_ZERO32;
      err_q <= 1'b0;
    end else if (rd_setup) begin
      rdata_q <= pwrite ? PTG_ZERO32 : rd_mux;
      err_q <= !addr_ok;
    end
  end
  assign prdata = rdata_q;

  // control register; a hardware stop clears run unless software
  // writes in the same cycle, software intent wins there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PTG_CTRL_RST;
    end else if (wr_en && paddr == PTG_CTRL_OFS) begin
      ctrl_q.run <= pwdata[PTG_RUN_BIT];
      ctrl_q.clk_src_ext <= pwdata[PTG_SRC_BIT];
      ctrl_q.prescale_select <= pwdata[PTG_PRE_LSB +: 3];
      ctrl_q.postscale_select <= pwdata[PTG_POST_LSB +: 4];
    end else if (hw_stop) begin
      ctrl_q.run <= 1'b0; // RQ2
    end
  end

  // mode, period and interrupt enable registers
  // codes are stored as written; reserved ones simply hold the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= PTG_M_SW_GATE;
      period_q <= PTG_PERIOD_RST;
      irq_en_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == PTG_MODE_OFS) begin
        mode_q <= ptg_mode_t'(pwdata[4:0]);
      end
      if (paddr == PTG_PERIOD_OFS) begin
        period_q <= pwdata[COUNT_W-1:0];
      end
      if (paddr == PTG_IEN_OFS) begin
        irq_en_q <= pwdata[PTG_IRQ_BIT];
      end
    end
  end

endmodule

// ---- tb/ptg_timer_assertions.sv ----
`timescale 1ns/100ps
module ptg_timer_assertions
  import ptg_pkg::*;
#(
  parameter int COUNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_clock_in,
  input wire logic ext_gate_reset_input,
  input wire logic [COUNT_W-1:0] count_value,
  input wire logic postscaled_match,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // access phase; writes land at its closing edge
  assign acc = psel && penable;
  a_pready_tied: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (acc && paddr > PTG_IEN_OFS |-> pslverr)
    else $error("no pslverr on unmapped");
  a_read_unmapped: assert property
    (acc && !pwrite && paddr > PTG_IEN_OFS |-> prdata == '0)
    else $error("unmapped read not zero");
  // a count may step by one or wrap; anything else needs a write
  a_count_step: assert property (count_value != $past(count_value) |->
    count_value == $past(count_value) + 1'b1 || count_value == '0 ||
    $past(acc && pwrite && paddr == PTG_COUNT_OFS))
    else $error("count jumped");
  a_match_zero: assert property (postscaled_match |->
    count_value == '0 || $past(acc && pwrite && paddr == PTG_COUNT_OFS))
    else $error("event without wrap");
  a_match_pulse: assert property (postscaled_match |=>
    !postscaled_match) else $error("event longer than one cycle");
  a_irq_rise: assert property ($rose(irq) |->
    $past(postscaled_match) || $past(postscaled_match, 2) ||
    $past(acc && pwrite && paddr == PTG_IEN_OFS))
    else $error("irq rose without cause");
  // only software may drop the request: clear or mask
  a_irq_fall: assert property ($fell(irq) |-> $past(acc && pwrite &&
    (paddr == PTG_CLR_OFS || paddr == PTG_IEN_OFS)))
    else $error("irq fell without write");
  c_event: cover property (postscaled_match);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule

// ---- tb/ptg_far_end.sv ----
`timescale 1ns/100ps
module ptg_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_on,
  input wire logic ext_req,
  output logic timer_clock_in,
  output logic ext_gate_reset_input
);
  logic [1:0] div_q;
  // timer clock at a quarter of pclk; stands still when not wanted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 2'h0;
    else if (clk_on) div_q <= div_q + 2'h1;
  end
  assign timer_clock_in = div_q[1];
  // gate/reset source changes just after a pclk edge, async to ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_gate_reset_input <= 1'b0;
    else ext_gate_reset_input <= ext_req;
  end
endmodule

// ---- tb/ptg_timer_bench.sv ----
`timescale 1ns/100ps
module ptg_timer_bench import ptg_pkg::*;;
  localparam int COUNT_W = 8;
  logic pclk, presetn, psel, penable, pwrite, clk_on, ext_req;
  logic pready, pslverr, timer_clock_in, ext_gate_reset_input;
  logic postscaled_match, irq, err;
  logic [7:0] paddr, count_value;
  logic [31:0] pwdata, prdata, rd;
  int fails = 0;
  int n_checks = 0;
  int c;
  // control word, period, pclk cycles between events
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] per;
    logic [31:0] gap;
  } ptg_row_t;
  ptg_row_t rows [6] = '{'{32'h0000_0001, 3, 4}, '{32'h0000_0011, 3, 8},
    '{32'h0000_0201, 3, 12}, '{32'h0000_0F01, 1, 32},
    '{32'h0000_0121, 2, 24}, '{32'h0000_0003, 3, 16}};
  logic [7:0] rst_a [4] = '{PTG_CTRL_OFS, PTG_PERIOD_OFS, PTG_COUNT_OFS,
    PTG_STAT_OFS};
  logic [31:0] rst_e [4] = '{32'h0, 32'hFF, 32'h0, 32'h0};
  ptg_timer #(.INSTR_DIV(1)) i_ptg_timer (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_clock_in,
    .ext_gate_reset_input, .count_value, .postscaled_match, .irq);
  ptg_far_end i_ptg_far_end (.pclk, .presetn, .clk_on, .ext_req,
    .timer_clock_in, .ext_gate_reset_input);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    fails++;
    end_sim();
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles until the next period event, sampled mid-cycle
  task automatic wm(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (postscaled_match !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask
  initial begin
    {presetn, psel, penable, pwrite, clk_on, ext_req} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // ratios and wrap spacing; second gap avoids leftover state
    foreach (rows[i]) begin
      clk_on <= rows[i].ctrl[PTG_SRC_BIT];
      apb(1, PTG_PERIOD_OFS, rows[i].per);
      apb(1, PTG_CTRL_OFS, rows[i].ctrl);
      wm(c);
      wm(c);
      chk("event gap", rows[i].gap, c);
      $display("row %0d done", i);
    end
    // irq raised, masked, cleared; run off holds the count
    apb(1, PTG_IEN_OFS, 32'h1);
    wm(c);
    repeat (3) @(negedge pclk);
    chk("irq", 1, irq);
    apb(1, PTG_CTRL_OFS, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1, PTG_IEN_OFS, 32'h0);
    @(negedge pclk);
    chk("irq masked", 0, irq);
    apb(1, PTG_IEN_OFS, 32'h1);
    @(negedge pclk);
    chk("irq unmasked", 1, irq);
    apb(0, PTG_STAT_OFS, 0);
    chk("status", 1, rd);
    apb(1, PTG_CLR_OFS, 32'h1);
    apb(0, PTG_STAT_OFS, 0);
    chk("status cleared", 0, rd);
    chk("irq cleared", 0, irq);
    apb(0, PTG_COUNT_OFS, 0);
    c = rd;
    repeat (30) @(posedge pclk);
    apb(0, PTG_COUNT_OFS, 0);
    chk("count held", c, rd);
    apb(0, 8'h1C, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    $display("irq test done");
    // gate modes: blocking level holds, opposite level counts
    clk_on <= 1'b0;
    for (int m = 1; m <= 2; m++) begin
      ext_req <= (m == 1);
      apb(1, PTG_PERIOD_OFS, 32'hF0);
      apb(1, PTG_MODE_OFS, m);
      apb(1, PTG_CTRL_OFS, 32'h1);
      apb(0, PTG_COUNT_OFS, 0);
      c = rd;
      repeat (20) @(posedge pclk);
      apb(0, PTG_COUNT_OFS, 0);
      chk("gated hold", c, rd);
      ext_req <= (m != 1);
      repeat (20) @(posedge pclk);
      apb(0, PTG_COUNT_OFS, 0);
      chk("gate open", 1, rd !== c);
    end
    $display("gate test done");
    // limit modes, rising edge: resets all but falling-only
    for (int m = 3; m <= 5; m++) begin
      ext_req <= 1'b0;
      apb(1, PTG_MODE_OFS, m);
      apb(1, PTG_COUNT_OFS, 0);
      repeat (60) @(posedge pclk);
      ext_req <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(0, PTG_COUNT_OFS, 0);
      chk("limit reset", m != 5, rd < 32'h20);
    end
    $display("limit test done");
    // one-shot clears run; edge-start stop keeps it
    for (int j = 0; j < 2; j++) begin
      ext_req <= 1'b0;
      apb(1, PTG_CTRL_OFS, 32'h0);
      apb(1, PTG_COUNT_OFS, 0);
      apb(1, PTG_PERIOD_OFS, 32'h5);
      apb(1, PTG_MODE_OFS, j ? 32'h11 : 32'h08);
      apb(1, PTG_CTRL_OFS, 32'h1);
      repeat (4) @(posedge pclk);
      ext_req <= 1'b1;
      repeat (40) @(posedge pclk);
      apb(0, PTG_CTRL_OFS, 0);
      chk("run after stop", j, rd);
      apb(0, PTG_COUNT_OFS, 0);
      chk("stopped count", 0, rd);
    end
    $display("stop test done");
    // second reset in mid-run restores reset values
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i]) begin
      apb(0, rst_a[i], 0);
      chk("reset value", rst_e[i], rd);
    end
    chk("reset irq", 0, irq);
    $display("reset test done");
    end_sim();
  end
endmodule
bind ptg_timer ptg_timer_assertions #(.COUNT_W(COUNT_W)) u_chk (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .timer_clock_in, .ext_gate_reset_input, .count_value,
  .postscaled_match, .irq);
